// >>> shared/wdt_map.vh
// Register map, field layout and counts of the watchdog and interval timer
// Operation
// - Run write clears counter, restarts from zero
// - Mode 00 stop, 01 interval, 10 NMI, 11 reset
// - Run bit set-only; only external reset stops
// - Mode bits set-only; no return to interval
// - Interval mode counts only after run write
// - Prescaler not cleared; first period may shorten
// - Watchdog select with flag set raises NMI
// - Two select bits choose four overflow periods
// - Watchdog overflow: NMI if action 0, else reset
// - Runs in halt, freezes in stop
// - Frozen while CPU runs on subsystem clock
// - Interval overflow raises masked top-priority interrupt
// - Interval overflow repeats every period unattended
// - Run bit7, mode bit4, action bit3, select bits2:1
// - Divide by 16/64/256/1024; 128 count clocks
// - Reset clears mode and select registers
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

`define WDT_ADDR_W          16
`define WDT_DATA_W          8

`define WDT_OFS_MODE        16'hFFF9
`define WDT_OFS_PERIOD      16'hFF42
`define WDT_OFS_REQ_FLAG    16'hFF00
`define WDT_OFS_REQ_MASK    16'hFF04
`define WDT_OFS_EVT_STATUS  16'hFF10
`define WDT_OFS_EVT_CLEAR   16'hFF11
`define WDT_OFS_EVT_ENABLE  16'hFF12

`define WDT_BIT_RUN         7
`define WDT_BIT_WD_SEL      4
`define WDT_BIT_ACTION      3
`define WDT_BIT_PSEL_HI     2
`define WDT_BIT_PSEL_LO     1
`define WDT_BIT_FLAG        0

`define WDT_EVT_INTERVAL    0
`define WDT_EVT_NMI         1
`define WDT_EVT_RESET       2
`define WDT_EVT_W           3

`define WDT_MODE_STOP       2'h0
`define WDT_MODE_INTERVAL   2'h1
`define WDT_MODE_WD_NMI     2'h2
`define WDT_MODE_WD_RESET   2'h3

`define WDT_RST_MODE        8'h00
`define WDT_RST_PERIOD      8'h00
`define WDT_RST_MASK        1'h1

`define WDT_PRESCALE_W      10
`define WDT_COUNT_W         7
`define WDT_COUNT_LAST      7'h7F

`endif

// >>> verilog/wdt_prescaler.v
// Free-running main-clock prescaler with selectable count-clock tick
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.vh"

module wdt_prescaler (
  input  wire       clk,
  input  wire       rst,
  input  wire       run_en,
  input  wire [1:0] period_sel,
  output wire       count_tick
);

  reg  [`WDT_PRESCALE_W-1:0] pre_ff;
  reg  [`WDT_PRESCALE_W-1:0] nxt_pre;
  reg                        tick;

  // Never cleared by a restart, so the first period may run short
  always @* begin
    nxt_pre = pre_ff;
    if (run_en) begin
      nxt_pre = pre_ff + {{(`WDT_PRESCALE_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_ff <= {`WDT_PRESCALE_W{1'b0}};
    end else begin
      pre_ff <= nxt_pre;
    end
  end

  // Tick on the last main clock of each division window
  always @* begin
    case (period_sel)
      2'h0:    tick = &pre_ff[3:0];
      2'h1:    tick = &pre_ff[5:0];
      2'h2:    tick = &pre_ff[7:0];
      2'h3:    tick = &pre_ff[9:0];
      default: tick = 1'b0;
    endcase
  end

  assign count_tick = tick & run_en;

endmodule // wdt_prescaler

`default_nettype wire

// >>> verilog/wdt_top.v
// Watchdog and interval timer with register port and interrupt logic
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.vh"

module wdt_top (
  input  wire                   clk,
  input  wire                   rst,
  input  wire [`WDT_ADDR_W-1:0] addr,
  input  wire [`WDT_DATA_W-1:0] wr_data,
  input  wire                   wr_en,
  input  wire                   rd_en,
  output wire [`WDT_DATA_W-1:0] rd_data,
  input  wire                   stop_mode,
  input  wire                   sub_clock_sel,
  output wire                   interval_overflow_interrupt,
  output wire                   nmi_req,
  output wire                   sys_reset_req,
  output wire                   irq
);

  // Register state
  reg                       run_ff;
  reg                       watchdog_mode_select_ff;
  reg                       overflow_action_select_ff;
  reg                       period_select_high_ff;
  reg                       period_select_low_ff;
  reg                       watchdog_request_flag_ff;
  reg                       watchdog_interrupt_mask_ff;
  reg  [`WDT_EVT_W-1:0]     evt_status_ff;
  reg  [`WDT_EVT_W-1:0]     evt_enable_ff;
  reg  [`WDT_COUNT_W-1:0]   count_ff;
  reg                       nmi_ff;
  reg                       reset_req_ff;
  reg  [`WDT_DATA_W-1:0]    rd_data_ff;

  // Next values
  reg                       nxt_run;
  reg                       nxt_wd_sel;
  reg                       nxt_action;
  reg                       nxt_psel_hi;
  reg                       nxt_psel_lo;
  reg                       nxt_flag;
  reg                       nxt_mask;
  reg  [`WDT_EVT_W-1:0]     nxt_evt_status;
  reg  [`WDT_EVT_W-1:0]     nxt_evt_enable;
  reg  [`WDT_COUNT_W-1:0]   nxt_count;
  reg                       nxt_nmi;
  reg                       nxt_reset_req;
  reg  [`WDT_DATA_W-1:0]    nxt_rd_data;

  wire [1:0]                mode;
  wire [1:0]                period_sel;
  wire                      clock_live;
  wire                      counting;
  wire                      count_tick;
  wire                      overflow;
  wire                      wr_mode;
  wire                      wr_period;
  wire                      wr_flag;
  wire                      wr_mask;
  wire                      wr_evt_clear;
  wire                      wr_evt_enable;
  wire                      restart;
  wire                      wd_newly_selected;
  wire                      late_nmi;
  wire [`WDT_EVT_W-1:0]     evt_set;

  // Reset images of the two control registers
  localparam [`WDT_DATA_W-1:0] reset_mode   = `WDT_RST_MODE;
  localparam [`WDT_DATA_W-1:0] reset_period = `WDT_RST_PERIOD;

  // Mode decode helpers
  function is_watchdog;
    input [1:0] m;
    begin
      is_watchdog = m[1];
    end
  endfunction

  function is_interval;
    input [1:0] m;
    begin
      is_interval = (m == `WDT_MODE_INTERVAL);
    end
  endfunction

  function is_stopped;
    input [1:0] m;
    begin
      is_stopped = (m == `WDT_MODE_STOP);
    end
  endfunction

  // A written 0 leaves a set-only control bit untouched
  function set_only;
    input cur;
    input req;
    begin
      set_only = cur | req;
    end
  endfunction

  // Exact address match qualified by a strobe
  function hit;
    input                   en;
    input [`WDT_ADDR_W-1:0] a;
    input [`WDT_ADDR_W-1:0] ofs;
    begin
      hit = en & (a == ofs);
    end
  endfunction

  assign mode       = {watchdog_mode_select_ff, overflow_action_select_ff};
  assign period_sel = {period_select_high_ff, period_select_low_ff};

  // Main clock gone to the counter in stop or on the subsystem clock
  assign clock_live = ~stop_mode & ~sub_clock_sel;

  // Mode alone does not start the count; run must also be set
  assign counting = run_ff & ~is_stopped(mode) & clock_live;

  wdt_prescaler u_prescaler (
    .clk        (clk),
    .rst        (rst),
    .run_en     (clock_live),
    .period_sel (period_sel),
    .count_tick (count_tick)
  );

  assign overflow = counting & count_tick & (count_ff == `WDT_COUNT_LAST);

  assign wr_mode       = hit(wr_en, addr, `WDT_OFS_MODE);
  assign wr_period     = hit(wr_en, addr, `WDT_OFS_PERIOD);
  assign wr_flag       = hit(wr_en, addr, `WDT_OFS_REQ_FLAG);
  assign wr_mask       = hit(wr_en, addr, `WDT_OFS_REQ_MASK);
  assign wr_evt_clear  = hit(wr_en, addr, `WDT_OFS_EVT_CLEAR);
  assign wr_evt_enable = hit(wr_en, addr, `WDT_OFS_EVT_ENABLE);

  assign restart = wr_mode & wr_data[`WDT_BIT_RUN];

  // Flag left standing when watchdog is first chosen
  assign wd_newly_selected = wr_mode & wr_data[`WDT_BIT_WD_SEL] &
                             ~watchdog_mode_select_ff;
  assign late_nmi = wd_newly_selected & watchdog_request_flag_ff;

  // Event sources for the sticky status register
  assign evt_set[`WDT_EVT_INTERVAL] = overflow & is_interval(mode);
  assign evt_set[`WDT_EVT_NMI]      = nxt_nmi;
  assign evt_set[`WDT_EVT_RESET]    = nxt_reset_req;

  // Mode bits: only ones stick, software cannot clear them; period select bits take each write
  always @* begin
    nxt_run     = run_ff;
    nxt_wd_sel  = watchdog_mode_select_ff;
    nxt_action  = overflow_action_select_ff;
    nxt_psel_hi = period_select_high_ff;
    nxt_psel_lo = period_select_low_ff;
    if (wr_mode) begin
      nxt_run    = set_only(run_ff, wr_data[`WDT_BIT_RUN]);
      nxt_wd_sel = set_only(watchdog_mode_select_ff, wr_data[`WDT_BIT_WD_SEL]);
      nxt_action = set_only(overflow_action_select_ff, wr_data[`WDT_BIT_ACTION]);
    end
    if (wr_period) begin
      nxt_psel_hi = wr_data[`WDT_BIT_PSEL_HI];
      nxt_psel_lo = wr_data[`WDT_BIT_PSEL_LO];
    end
  end

  // Counter: restart wins over a tick in the same cycle
  always @* begin
    nxt_count = count_ff;
    if (restart) begin
      nxt_count = {`WDT_COUNT_W{1'b0}};
    end else if (counting & count_tick) begin
      // Wraps on overflow so interval mode repeats untouched
      nxt_count = count_ff + {{(`WDT_COUNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Overflow actions
  always @* begin
    nxt_nmi       = late_nmi;
    nxt_reset_req = 1'b0;
    if (overflow & is_watchdog(mode)) begin
      if (overflow_action_select_ff) begin
        nxt_reset_req = 1'b1;
      end else begin
        nxt_nmi = 1'b1;
      end
    end
  end

  // Request flag: overflow set beats a software clear
  always @* begin
    nxt_flag = watchdog_request_flag_ff;
    if (wr_flag & ~wr_data[`WDT_BIT_FLAG]) begin
      nxt_flag = 1'b0;
    end
    if (overflow) begin
      nxt_flag = 1'b1;
    end
  end

  always @* begin
    nxt_mask = watchdog_interrupt_mask_ff;
    if (wr_mask) begin
      nxt_mask = wr_data[`WDT_BIT_FLAG];
    end
  end

  // Sticky event bits, set wins over clear
  always @* begin
    nxt_evt_status = evt_status_ff;
    if (wr_evt_clear) begin
      nxt_evt_status = evt_status_ff & ~wr_data[`WDT_EVT_W-1:0];
    end
    nxt_evt_status = nxt_evt_status | evt_set;
    nxt_evt_enable = evt_enable_ff;
    if (wr_evt_enable) begin
      nxt_evt_enable = wr_data[`WDT_EVT_W-1:0];
    end
  end

  // Read mux; unmapped and write-only addresses read zero
  always @* begin
    nxt_rd_data = {`WDT_DATA_W{1'b0}};
    if (rd_en) begin
      case (addr)
        `WDT_OFS_MODE: begin
          nxt_rd_data[`WDT_BIT_RUN]    = run_ff;
          nxt_rd_data[`WDT_BIT_WD_SEL] = watchdog_mode_select_ff;
          nxt_rd_data[`WDT_BIT_ACTION] = overflow_action_select_ff;
        end
        `WDT_OFS_PERIOD: begin
          nxt_rd_data[`WDT_BIT_PSEL_HI] = period_select_high_ff;
          nxt_rd_data[`WDT_BIT_PSEL_LO] = period_select_low_ff;
        end
        `WDT_OFS_REQ_FLAG: begin
          nxt_rd_data[`WDT_BIT_FLAG] = watchdog_request_flag_ff;
        end
        `WDT_OFS_REQ_MASK: begin
          nxt_rd_data[`WDT_BIT_FLAG] = watchdog_interrupt_mask_ff;
        end
        `WDT_OFS_EVT_STATUS: begin
          nxt_rd_data[`WDT_EVT_W-1:0] = evt_status_ff;
        end
        `WDT_OFS_EVT_ENABLE: begin
          nxt_rd_data[`WDT_EVT_W-1:0] = evt_enable_ff;
        end
        default: begin
          nxt_rd_data = {`WDT_DATA_W{1'b0}};
        end
      endcase
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      run_ff                     <= reset_mode[`WDT_BIT_RUN];
      watchdog_mode_select_ff    <= reset_mode[`WDT_BIT_WD_SEL];
      overflow_action_select_ff  <= reset_mode[`WDT_BIT_ACTION];
      period_select_high_ff      <= reset_period[`WDT_BIT_PSEL_HI];
      period_select_low_ff       <= reset_period[`WDT_BIT_PSEL_LO];
      watchdog_request_flag_ff   <= 1'b0;
      watchdog_interrupt_mask_ff <= `WDT_RST_MASK;
      evt_status_ff              <= {`WDT_EVT_W{1'b0}};
      evt_enable_ff              <= {`WDT_EVT_W{1'b0}};
      count_ff                   <= {`WDT_COUNT_W{1'b0}};
      nmi_ff                     <= 1'b0;
      reset_req_ff               <= 1'b0;
      rd_data_ff                 <= {`WDT_DATA_W{1'b0}};
    end else begin
      run_ff                     <= nxt_run;
      watchdog_mode_select_ff    <= nxt_wd_sel;
      overflow_action_select_ff  <= nxt_action;
      period_select_high_ff      <= nxt_psel_hi;
      period_select_low_ff       <= nxt_psel_lo;
      watchdog_request_flag_ff   <= nxt_flag;
      watchdog_interrupt_mask_ff <= nxt_mask;
      evt_status_ff              <= nxt_evt_status;
      evt_enable_ff              <= nxt_evt_enable;
      count_ff                   <= nxt_count;
      nmi_ff                     <= nxt_nmi;
      reset_req_ff               <= nxt_reset_req;
      rd_data_ff                 <= nxt_rd_data;
    end
  end

  // Registered outputs
  assign rd_data       = rd_data_ff;
  assign nmi_req       = nmi_ff;
  assign sys_reset_req = reset_req_ff;

  // Maskable path only exists in interval mode; CPU gives it top priority
  assign interval_overflow_interrupt = watchdog_request_flag_ff &
                                       ~watchdog_interrupt_mask_ff &
                                       is_interval(mode);

  assign irq = |(evt_status_ff & evt_enable_ff);

endmodule // wdt_top

`default_nettype wire

// >>> verification/wdt_chk_sva.sv
// Port checker of the watchdog and interval timer
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.vh"
module wdt_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wr_data,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [7:0]  rd_data,
  input wire logic        stop_mode,
  input wire logic        sub_clock_sel,
  input wire logic        interval_overflow_interrupt,
  input wire logic        nmi_req,
  input wire logic        sys_reset_req,
  input wire logic        irq
);
  logic        run_ff, wd_ff, act_ff, msk_ff;
  logic [11:0] age_ff;
  wire         wm = wr_en && addr == `WDT_OFS_MODE;
  wire         iv = interval_overflow_interrupt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Set-only shadows of the mode bits, cycles since last restart
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {run_ff, wd_ff, act_ff, msk_ff} <= 4'h1;
      age_ff <= 12'hFFF;
    end else begin
      run_ff <= run_ff | (wm & wr_data[7]);
      wd_ff <= wd_ff | (wm & wr_data[4]);
      act_ff <= act_ff | (wm & wr_data[3]);
      if (wr_en && addr == `WDT_OFS_REQ_MASK) msk_ff <= wr_data[0];
      if (wm && wr_data[7]) age_ff <= 12'h000;
      else if (age_ff != 12'hFFF) age_ff <= age_ff + 12'h001;
    end
  end
  property p_mode_rd;
    rd_en && addr == `WDT_OFS_MODE |=> rd_data == {run_ff, 2'h0, wd_ff, act_ff, 3'h0};
  endproperty
  property p_idle; !rd_en |=> rd_data == 8'h00; endproperty
  property p_mask; msk_ff |-> !iv; endproperty
  property p_ivmode; !(act_ff && !wd_ff) |-> !iv; endproperty
  property p_norun; !run_ff |-> !iv && !sys_reset_req; endproperty
  property p_pulse; nmi_req |=> !nmi_req; endproperty
  property p_srst; sys_reset_req |-> wd_ff && act_ff && !nmi_req; endproperty
  property p_nmi; nmi_req |-> wd_ff; endproperty
  property p_stop; stop_mode [*2] |-> !sys_reset_req; endproperty
  property p_sub; sub_clock_sel [*2] |-> !sys_reset_req; endproperty
  // A restart in the overflow cycle still lets that overflow out
  property p_age; sys_reset_req && age_ff != 12'h000 |-> age_ff > 12'h7D0; endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode readback");
  a_idle: assert property (p_idle) else $error("read data not idle");
  a_mask: assert property (p_mask) else $error("masked request");
  a_ivmode: assert property (p_ivmode) else $error("request in wrong mode");
  a_norun: assert property (p_norun) else $error("overflow without run");
  a_pulse: assert property (p_pulse) else $error("long nmi");
  a_srst: assert property (p_srst) else $error("reset in wrong mode");
  a_nmi: assert property (p_nmi) else $error("nmi in wrong mode");
  a_stop: assert property (p_stop) else $error("counting in stop");
  a_sub: assert property (p_sub) else $error("counting on subclock");
  a_age: assert property (p_age) else $error("overflow too early");
  c_nmi: cover property (nmi_req);
  c_srst: cover property (sys_reset_req);
  c_irq: cover property ($rose(irq));
endmodule // wdt_chk
bind wdt_top wdt_chk i_wdt_chk (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .stop_mode(stop_mode),
  .sub_clock_sel(sub_clock_sel), .interval_overflow_interrupt(interval_overflow_interrupt),
  .nmi_req(nmi_req), .sys_reset_req(sys_reset_req), .irq(irq));
`default_nettype wire

// >>> verification/test_wdt_top.sv
// Self-checking testbench of the watchdog and interval timer
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.vh"
module test_wdt_top;
  localparam logic [15:0] MD = `WDT_OFS_MODE;
  localparam logic [15:0] PS = `WDT_OFS_PERIOD;
  localparam logic [15:0] FL = `WDT_OFS_REQ_FLAG;
  localparam logic [15:0] MK = `WDT_OFS_REQ_MASK;
  logic        clk, rst, wr_en, rd_en, stop_mode, sub_clock_sel;
  logic [15:0] addr;
  logic [7:0]  wr_data;
  wire  [7:0]  rd_data;
  wire         iv, nmi, srst, irq;
  int          n_errors = 0;
  int          checked = 0;
  int          m_mode, c, i;
  logic [15:0] lfsr = 16'hEF42;
  wdt_top i_wdt_top (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .stop_mode(stop_mode), .sub_clock_sel(sub_clock_sel),
    .interval_overflow_interrupt(iv), .nmi_req(nmi), .sys_reset_req(srst), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    m_mode = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask
  // Model keeps the set-only mode bits
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    if (a == MD) m_mode = m_mode | (d & 8'h98);
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rd_data, exp);
  endtask
  function automatic logic ev(input int w);
    return w == 0 ? iv : (w == 1 ? nmi : srst);
  endfunction
  // Looks first in the cycle right after the caller's last edge
  task automatic wait_ev(input int w, input int lim);
    c = 0;
    #1;
    while (ev(w) !== 1'b1 && c < lim) begin
      @(posedge clk);
      #1 c = c + 1;
    end
    if (c >= lim) begin
      n_errors++;
      $display("wrong value at %0t ns: awaited output never rose", $time);
      tally_and_finish();
    end
  endtask
  initial begin
    {rst, wr_en, rd_en, stop_mode, sub_clock_sel} = 5'h10;
    addr = 16'h0000;
    wr_data = 8'h00;
    do_reset();
    rd(MD, 8'h00);
    rd(PS, 8'h00);
    rd(MK, 8'h01);
    rd(16'h1234, 8'h00);
    for (i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      wr(PS, lfsr[7:0]);
      rd(PS, lfsr[7:0] & 8'h06);
    end
    wr(PS, 8'h00);
    $display("test registers done");
    wr(MD, 8'h08);
    repeat (2100) @(posedge clk);
    rd(FL, 8'h00);
    wr(MK, 8'h00);
    wr(`WDT_OFS_EVT_ENABLE, 8'h01);
    wr(MD, 8'h80);
    wait_ev(0, 2100);
    chk({7'h0, c >= 2030 && c <= 2050}, 8'h01);
    chk({7'h0, irq}, 8'h01);
    rd(`WDT_OFS_EVT_STATUS, 8'h01);
    wr(`WDT_OFS_EVT_CLEAR, 8'h01);
    #1 chk({7'h0, irq}, 8'h00);
    wr(PS, 8'h02);
    wr(FL, 8'h00);
    wait_ev(0, 8300);
    wr(FL, 8'h00);
    wait_ev(0, 8300);
    chk({7'h0, c >= 8180 && c <= 8192}, 8'h01);
    wr(MD, 8'h00);
    rd(MD, m_mode[7:0]);
    wr(MK, 8'h01);
    #1 chk({7'h0, iv}, 8'h00);
    $display("test interval done");
    wr(FL, 8'h00);
    stop_mode <= 1'b1;
    repeat (8300) @(posedge clk);
    rd(FL, 8'h00);
    @(posedge clk);
    stop_mode <= 1'b0;
    sub_clock_sel <= 1'b1;
    repeat (8300) @(posedge clk);
    rd(FL, 8'h00);
    @(posedge clk);
    sub_clock_sel <= 1'b0;
    $display("test freeze done");
    do_reset();
    wr(MD, 8'h90);
    for (i = 0; i < 3; i++) begin
      repeat (1500) @(posedge clk);
      wr(MD, 8'h80);
    end
    rd(FL, 8'h00);
    wait_ev(1, 2100);
    chk({7'h0, c >= 2020 && c <= 2050}, 8'h01);
    $display("test watchdog nmi done");
    do_reset();
    wr(MK, 8'h00);
    wr(MD, 8'h88);
    wait_ev(0, 2100);
    wr(MD, 8'h98);
    wait_ev(1, 1);
    #1 chk({7'h0, iv}, 8'h00);
    wr(FL, 8'h00);
    wait_ev(2, 2100);
    rd(`WDT_OFS_EVT_STATUS, 8'h07);
    $display("test watchdog reset done");
    tally_and_finish();
  end
endmodule // test_wdt_top
`default_nettype wire
